// ### design/qrsp_bank.sv
// One burst-word bank of the array, with per-lane write masking.
// Assumes writes come from the commit pulse of the port logic.
`timescale 1ns/1ps
module qrsp_bank #(
	parameter int ADDR_W = 21
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic we,
	input wire logic [ADDR_W-1:0] waddr,
	input wire logic [qrsp_pkg::DATA_W-1:0] wdata,
	input wire logic [qrsp_pkg::LANES-1:0] wmask_n,
	input wire logic [ADDR_W-1:0] raddr,
	output logic [qrsp_pkg::DATA_W-1:0] rdata
);
	import qrsp_pkg::*;
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // Storage, no reset by design

	// Combinational read so forwarding can merge in the same cycle
	assign rdata = mem[raddr];

	// One writer process; each lane writes only when its mask is low
	always_ff @(posedge clk) begin
		if (ce && we) begin
			for (int l = 0; l < LANES; l++) begin
				if (!wmask_n[l]) begin
					mem[waddr][l*LANE_W +: LANE_W] <= wdata[l*LANE_W +: LANE_W];
				end
			end
		end
	end

	// A masked lane keeps its old contents
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		a_lane_kept: assert property (@(posedge clk) ce && we && wmask_n[l] |=>
			mem[$past(waddr)][l*LANE_W +: LANE_W] == $past(mem[waddr][l*LANE_W +: LANE_W]))
			else $error("masked lane was written");
	end
endmodule // qrsp_bank

// ### design/qrsp_pkg.sv
// Shared constants for the burst SRAM port logic: pin vector layout,
// register map, timing figures and state encodings.
// Assumes a 100 MHz system clock sampling all pins.
package qrsp_pkg;
	// Data path shape
	localparam int DATA_W = 18; // One burst word
	localparam int LANE_W = 9; // One byte lane
	localparam int LANES = 2; // Lanes per word
	localparam int BEATS = 4; // Words per burst
	// Control bit positions above address and data in the pin vector
	localparam int PIN_MS = 0;
	localparam int PIN_MSN = 1;
	localparam int PIN_OTR = 2;
	localparam int PIN_OTRN = 3;
	localparam int PIN_RPS = 4;
	localparam int PIN_WPS = 5;
	localparam int PIN_MASK = 6;
	localparam int PIN_BYP = 8;
	localparam int PIN_CTL_W = 9;
	localparam int CLK_PINS = 4;
	// Register map (byte addresses)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_CALCNT = 4'h8;
	localparam int CTRL_CAL_EN = 0; // Impedance update enable
	localparam logic CTRL_RESET = 1'h1;
	localparam int ST_LOCK = 0;
	localparam int ST_SINGLE = 1;
	localparam int ST_WR_BUSY = 2;
	localparam int ST_RD_BUSY = 3;
	localparam int ST_BYPASS = 4;
	localparam int CAL_W = 16;
	// Timing
	localparam int CLK_NS = 10;
	localparam int PLL_LOCK_US = 20;
	localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int PLL_STOP_NS = 30;
	localparam int LINK_HALF_NS = 40; // Normal gap between strobe edges
	localparam int PLL_STOP_CYC = (LINK_HALF_NS + PLL_STOP_NS + CLK_NS - 1) / CLK_NS;
	localparam int ZQ_PERIOD = 1024;
	localparam logic [1:0] STRAP_WAIT = 2'h3; // Synchroniser fill time
	// Write engine states
	typedef enum logic [0:0] {
		WR_IDLE = 1'b0,
		WR_BEATS = 1'b1
	} qrsp_wr_state_t;
endpackage

// ### design/qrsp_port.sv
// Pin-level port logic of a four-word burst SRAM with separate ports.
// Assumes all pins come from outside the clk domain; an Avalon-MM
// master reaches the control and status registers.
// Functional notes
// - Write starts on strobe rise with select low
// - Capture four words, commit 72 bits together
// - Back-to-back write start is ignored
// - Deselected write port finishes burst, then idles
// - Lane masks sampled with every data word
// - Masked lane leaves stored byte unchanged
// - Mask zero bits 8:0, one bits 17:9
// - Strap high output refs select single-clock mode
// - Read returns newest data, forwarding pending writes
// - Both selected: read first unless read before
// - Selects sampled on strobe rise, a read start blocks a write start
// - Impedance update every 1024 strobe cycles
// - Free-running returned strobes follow output clocks
// - PLL locks 20 us after stable clock
// - Strobe stop of 30 ns resets PLL
// - Bypass low: PLL off, one-cycle latency
// - Read latency 1.5 cycles, or 1 bypassed
// - Read words at t+1 to t+3 edges
// - Burst words map to banks 0..3 at A in order
// - Power-up deselected, outputs high impedance
// - Write data on both strobes, reads on refs
// - Select used last start is don't-care next
`timescale 1ns/1ps
module qrsp_port #(
	parameter int ADDR_W = 21,
	parameter int PLL_LOCK_CYCLES = qrsp_pkg::PLL_LOCK_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic master_strobe,
	input wire logic master_strobe_n,
	input wire logic output_timing_ref,
	input wire logic output_timing_ref_n,
	input wire logic read_port_select_n,
	input wire logic write_port_select_n,
	input wire logic [qrsp_pkg::LANES-1:0] lane_write_mask_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [qrsp_pkg::DATA_W-1:0] write_data,
	input wire logic pll_bypass,
	output logic [qrsp_pkg::DATA_W-1:0] read_data,
	output logic read_data_oe,
	output logic returned_strobe,
	output logic returned_strobe_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import qrsp_pkg::*;
	localparam int B = DATA_W + ADDR_W; // Control pins start here
	localparam int PW = B + PIN_CTL_W;
	localparam int ZQ_W = $clog2(ZQ_PERIOD);
	localparam int LK_W = $clog2(PLL_LOCK_CYCLES + 1);
	localparam int ST_W = $clog2(PLL_STOP_CYC + 1);

	// Refuse shapes the array and counters cannot serve
	if (ADDR_W < 1 || ADDR_W > 21 || PLL_LOCK_CYCLES < 1) begin : g_bad
		$error("qrsp_port: unsupported parameter");
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset || !ce);

	logic [PW-1:0] pin_in; // All pins as one vector
	logic [PW-1:0] s1_q; // First synchroniser stage, read only by s2_q
	logic [PW-1:0] s2_q; // Pins in clk domain
	logic [CLK_PINS-1:0] ck_prev_q; // Last level of each strobe pin
	logic [CLK_PINS-1:0] ck_rise;
	assign pin_in = {pll_bypass, lane_write_mask_n, write_port_select_n, read_port_select_n,
		output_timing_ref_n, output_timing_ref, master_strobe_n, master_strobe, addr, write_data};

	// Two-stage synchroniser for every pin
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_q <= '0;
			s2_q <= '0;
			ck_prev_q <= '0;
		end else if (ce) begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			ck_prev_q <= s2_q[B +: CLK_PINS];
		end
	end
	// Decoded pin fields
	logic [DATA_W-1:0] din;
	logic [ADDR_W-1:0] ain;
	logic [LANES-1:0] mask_in;
	logic read_port_select, write_port_select, byp, k_rise, kn_rise;
	assign din = s2_q[DATA_W-1:0];
	assign ain = s2_q[DATA_W +: ADDR_W];
	assign mask_in = s2_q[B + PIN_MASK +: LANES];
	assign read_port_select = !s2_q[B + PIN_RPS];
	assign write_port_select = !s2_q[B + PIN_WPS];
	assign byp = s2_q[B + PIN_BYP];
	assign k_rise = ck_rise[PIN_MS];
	assign kn_rise = ck_rise[PIN_MSN];

	// Single-clock strap, caught once after the synchroniser fills
	logic [1:0] strap_cnt_q;
	logic strap_done_q;
	logic single_q; // Output registers follow the master strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strap_cnt_q <= '0;
			strap_done_q <= 1'b0;
			single_q <= 1'b0;
		end else if (ce && !strap_done_q) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == STRAP_WAIT) begin
				strap_done_q <= 1'b1;
				single_q <= s2_q[B + PIN_OTR] && s2_q[B + PIN_OTRN];
			end
		end
	end
	// No edges until the edge history holds real pin levels, so a parked
	// strobe does not look like a rise right after reset
	assign ck_rise = (s2_q[B +: CLK_PINS] & ~ck_prev_q) & {CLK_PINS{strap_done_q}};

	// Output clock selection per strap
	logic oc_lvl, ocn_lvl, oc_rise, ocn_rise;
	assign oc_lvl = single_q ? s2_q[B + PIN_MS] : s2_q[B + PIN_OTR];
	assign ocn_lvl = single_q ? s2_q[B + PIN_MSN] : s2_q[B + PIN_OTRN];
	assign oc_rise = single_q ? ck_rise[PIN_MS] : ck_rise[PIN_OTR];
	assign ocn_rise = single_q ? ck_rise[PIN_MSN] : ck_rise[PIN_OTRN];

	// Free-running returned strobes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			returned_strobe <= 1'b0;
			returned_strobe_n <= 1'b0;
		end else if (ce) begin
			returned_strobe <= oc_lvl;
			returned_strobe_n <= ocn_lvl;
		end
	end
	a_echo_follow: assert property (##1 returned_strobe == $past(oc_lvl))
		else $error("returned strobe does not follow output clock");

	// Start decode; a start blocks the same kind on the next rise
	logic rd_prev_q, wr_prev_q; // Start kind of the last strobe rise
	logic rd_go, wr_go;
	assign rd_go = k_rise && read_port_select && !rd_prev_q;
	assign wr_go = k_rise && write_port_select && !wr_prev_q && !rd_go;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
		end else if (ce && k_rise) begin
			rd_prev_q <= rd_go;
			wr_prev_q <= wr_go;
		end
	end
	a_wr_no_repeat: assert property (k_rise && wr_prev_q |-> !wr_go)
		else $error("write started on consecutive strobe rises");
	a_arb_read_first: assert property (k_rise && read_port_select && write_port_select && !rd_prev_q |-> rd_go && !wr_go)
		else $error("read lost arbitration");

	// Write engine: address, beat counter and one queued start
	qrsp_wr_state_t wr_state_q;
	logic [1:0] wr_beat_q;
	logic [ADDR_W-1:0] wr_addr_q, nx_addr_q, fw_addr_q;
	logic nx_v_q; // Start taken while a burst is still arriving
	logic [BEATS-1:0] fw_got_q; // Words held in the write register
	logic [DATA_W-1:0] wr_word_q [BEATS];
	logic [LANES-1:0] wr_mask_q [BEATS];
	logic commit_q; // One-cycle array write of the whole burst
	logic cap;
	assign cap = wr_state_q == WR_BEATS && (wr_beat_q[0] ? kn_rise : k_rise);

	// Burst sequencing; deselect only stops new starts
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_state_q <= WR_IDLE;
			wr_beat_q <= '0;
			wr_addr_q <= '0;
			nx_addr_q <= '0;
			nx_v_q <= 1'b0;
			commit_q <= 1'b0;
		end else if (ce) begin
			commit_q <= cap && wr_beat_q == 2'h3;
			if (wr_go) begin
				if (wr_state_q == WR_IDLE) begin
					wr_state_q <= WR_BEATS;
					wr_addr_q <= ain;
					wr_beat_q <= '0;
				end else begin
					nx_v_q <= 1'b1; // Pipelined start, every other rise
					nx_addr_q <= ain;
				end
			end
			if (cap) begin
				wr_beat_q <= wr_beat_q + 2'h1;
				if (wr_beat_q == 2'h3) begin
					case (wr_state_q)
						WR_BEATS: begin
							wr_state_q <= nx_v_q ? WR_BEATS : WR_IDLE;
							wr_addr_q <= nx_addr_q;
							nx_v_q <= 1'b0;
						end
						default: wr_state_q <= WR_IDLE;
					endcase
				end
			end
		end
	end

	// Word and mask capture, also the forwarding source
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fw_addr_q <= '0;
			fw_got_q <= '0;
			for (int i = 0; i < BEATS; i++) begin
				wr_word_q[i] <= '0;
				wr_mask_q[i] <= '1;
			end
		end else if (ce && cap) begin
			wr_word_q[wr_beat_q] <= din;
			wr_mask_q[wr_beat_q] <= mask_in;
			if (wr_beat_q == 2'h0) begin
				fw_addr_q <= wr_addr_q;
				fw_got_q <= 4'h1;
			end else begin
				fw_got_q[wr_beat_q] <= 1'b1;
			end
		end
	end

	sequence s_last_beat;
		cap && wr_beat_q == 2'h3;
	endsequence
	sequence s_commit;
		commit_q && fw_got_q == 4'hF;
	endsequence
	a_commit_burst: assert property (s_last_beat |=> s_commit)
		else $error("burst not committed after fourth word");
	a_mask_beat: assert property (cap |=> wr_mask_q[$past(wr_beat_q)] == $past(mask_in))
		else $error("lane mask not taken with its word");

	// Read slots: head is being output, tail waits behind it
	logic hd_v_q, hd_arm_q, tl_v_q, tl_arm_q;
	logic [ADDR_W-1:0] hd_addr_q, tl_addr_q;
	logic [1:0] rd_idx_q; // Next word of the head burst
	logic hd_arm, first_edge, second_edge, emit, pop;
	assign hd_arm = hd_arm_q || (hd_v_q && k_rise); // Armed from t+1 on
	// Latency choice: half a cycle later when the PLL is in use
	assign first_edge = byp ? ocn_rise : oc_rise;
	assign second_edge = byp ? oc_rise : ocn_rise;
	assign emit = hd_v_q && hd_arm && (rd_idx_q[0] ? second_edge : first_edge);
	assign pop = emit && rd_idx_q == 2'h3;

	// Slot bookkeeping
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hd_v_q <= 1'b0;
			hd_arm_q <= 1'b0;
			tl_v_q <= 1'b0;
			tl_arm_q <= 1'b0;
			hd_addr_q <= '0;
			tl_addr_q <= '0;
			rd_idx_q <= '0;
		end else if (ce) begin
			if (k_rise) begin
				hd_arm_q <= hd_v_q;
				tl_arm_q <= tl_v_q;
			end
			if (emit) begin
				rd_idx_q <= rd_idx_q + 2'h1;
			end
			if (pop) begin
				hd_v_q <= tl_v_q;
				hd_arm_q <= tl_arm_q || (tl_v_q && k_rise);
				hd_addr_q <= tl_addr_q;
				tl_v_q <= 1'b0;
				tl_arm_q <= 1'b0;
			end
			if (rd_go) begin
				if ((hd_v_q && !pop) || (pop && tl_v_q)) begin
					tl_v_q <= 1'b1;
					tl_arm_q <= 1'b0;
					tl_addr_q <= ain;
				end else begin
					hd_v_q <= 1'b1;
					hd_arm_q <= 1'b0;
					hd_addr_q <= ain;
				end
			end
		end
	end

	// Array banks, one per burst word
	logic [DATA_W-1:0] bank_q [BEATS];
	for (genvar w = 0; w < BEATS; w++) begin : g_bank
		qrsp_bank #(.ADDR_W(ADDR_W)) u_bank (
			.clk(clk),
			.ce(ce),
			.we(commit_q),
			.waddr(fw_addr_q),
			.wdata(wr_word_q[w]),
			.wmask_n(wr_mask_q[w]),
			.raddr(hd_addr_q),
			.rdata(bank_q[w])
		);
	end

	// Forward enabled lanes of a held write to the same address
	logic [DATA_W-1:0] rd_word;
	logic fw_hit;
	always_comb begin
		fw_hit = fw_addr_q == hd_addr_q && fw_got_q[rd_idx_q];
		rd_word = bank_q[rd_idx_q];
		for (int l = 0; l < LANES; l++) begin
			if (fw_hit && !wr_mask_q[rd_idx_q][l]) begin
				rd_word[l*LANE_W +: LANE_W] = wr_word_q[rd_idx_q][l*LANE_W +: LANE_W];
			end
		end
	end

	// Output register; idle output clock rise releases the pins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			read_data <= '0;
			read_data_oe <= 1'b0;
		end else if (ce) begin
			if (emit) begin
				read_data <= rd_word;
				read_data_oe <= 1'b1;
			end else if (oc_rise) begin
				read_data_oe <= 1'b0;
			end
		end
	end
	a_first_word_edge: assert property (emit && rd_idx_q == 2'h0 |-> (byp ? ocn_rise : oc_rise))
		else $error("first read word on wrong output edge");
	a_idle_hiz: assert property (oc_rise && !emit |=> !read_data_oe)
		else $error("outputs driven with no read word");
	a_stop_freeze: assert property (ck_rise == '0 && !hd_v_q && wr_state_q == WR_IDLE
		|=> $stable(read_data) && $stable(read_data_oe))
		else $error("outputs changed with strobes stopped");

	// PLL model: stop detector, lock timer
	logic [ST_W-1:0] idle_cnt_q;
	logic [LK_W-1:0] lock_cnt_q;
	logic locked_q;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			idle_cnt_q <= '0;
			lock_cnt_q <= '0;
			locked_q <= 1'b0;
		end else if (ce) begin
			if (k_rise || kn_rise) begin
				idle_cnt_q <= '0;
			end else if (idle_cnt_q != ST_W'(PLL_STOP_CYC)) begin
				idle_cnt_q <= idle_cnt_q + 1'b1;
			end
			if (!byp || idle_cnt_q == ST_W'(PLL_STOP_CYC)) begin
				lock_cnt_q <= '0;
				locked_q <= 1'b0;
			end else if (lock_cnt_q == LK_W'(PLL_LOCK_CYCLES)) begin
				locked_q <= 1'b1;
			end else begin
				lock_cnt_q <= lock_cnt_q + 1'b1;
			end
		end
	end
	a_pll_stop_reset: assert property (idle_cnt_q == ST_W'(PLL_STOP_CYC) |=> !locked_q)
		else $error("PLL not reset by stopped strobes");
	a_pll_lock_time: assert property ($rose(locked_q) |-> $past(lock_cnt_q) == LK_W'(PLL_LOCK_CYCLES))
		else $error("PLL lock time wrong");

	// Periodic impedance update counted in strobe cycles
	logic [ZQ_W-1:0] zq_cnt_q;
	logic [CAL_W-1:0] cal_cnt_q; // Updates performed
	logic cal_en_q; // Software enable
	logic zq_tick;
	assign zq_tick = k_rise && zq_cnt_q == ZQ_W'(ZQ_PERIOD - 1);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			zq_cnt_q <= '0;
			cal_cnt_q <= '0;
		end else if (ce && k_rise) begin
			zq_cnt_q <= zq_cnt_q + 1'b1;
			if (zq_tick && cal_en_q) begin
				cal_cnt_q <= cal_cnt_q + 1'b1;
			end
		end
	end
	a_zq_period: assert property (zq_tick && cal_en_q |=> cal_cnt_q == $past(cal_cnt_q) + 1'b1)
		else $error("impedance update missed");

	// Avalon-MM slave, one wait cycle per access
	logic [31:0] status;
	assign status = 32'({byp, hd_v_q, wr_state_q == WR_BEATS, single_q, locked_q});
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
			cal_en_q <= CTRL_RESET;
		end else if (ce) begin
			if ((avs_read || avs_write) && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				case (avs_address)
					REG_CTRL: avs_readdata <= 32'(cal_en_q);
					REG_STATUS: avs_readdata <= status;
					REG_CALCNT: avs_readdata <= 32'(cal_cnt_q);
					default: avs_readdata <= '0;
				endcase
			end else begin
				avs_waitrequest <= 1'b1;
				if (avs_write && !avs_waitrequest && avs_address == REG_CTRL) begin
					cal_en_q <= avs_writedata[CTRL_CAL_EN];
				end
			end
		end
	end
endmodule // qrsp_port

// ### sim/qrsp_ctrl_model.sv
// Behavioural memory controller facing the burst SRAM port pins.
// Assumes the bench calls slot once per 80 ns strobe period, stop between phases.
`timescale 1ns/1ps
module qrsp_ctrl_model #(
	parameter int ADDR_W = 4
) (
	output logic master_strobe,
	output logic master_strobe_n,
	output logic output_timing_ref,
	output logic output_timing_ref_n,
	output logic read_port_select_n,
	output logic write_port_select_n,
	output logic [qrsp_pkg::LANES-1:0] lane_write_mask_n,
	output logic [ADDR_W-1:0] addr,
	output logic [qrsp_pkg::DATA_W-1:0] write_data,
	input wire logic single_mode,
	input wire logic [qrsp_pkg::DATA_W-1:0] read_data,
	input wire logic read_data_oe,
	input wire logic returned_strobe,
	input wire logic returned_strobe_n
);
	import qrsp_pkg::*;
	logic [39:0] p1, p2, pn; // Pending beats, each word with its masks
	logic v1, v2, vn; // Beat slots in use
	int slot_n; // Strobe periods so far
	int rs_bad; // Returned strobe misses
	logic [DATA_W-1:0] cap_q[$]; // Captured read words
	int cap_h[$]; // Output edge index of each word
	// Zero-skew output refs; both high strap single-clock mode
	assign output_timing_ref = single_mode | master_strobe;
	assign output_timing_ref_n = single_mode | master_strobe_n;
	// Quiet link at time zero
	initial begin
		master_strobe = 1'b0;
		master_strobe_n = 1'b1;
		read_port_select_n = 1'b1;
		write_port_select_n = 1'b1;
		lane_write_mask_n = 2'h3;
		addr = '0;
		write_data = '0;
		{v1, v2, slot_n, rs_bad} = '0;
	end
	// Released lines toggle, so a stale value never looks valid
	task put_word(input logic v, input logic [19:0] w);
		write_data = v ? w[17:0] : ~write_data;
		lane_write_mask_n = v ? w[19:18] : ~lane_write_mask_n;
	endtask
	// Sample 35 ns after an output edge, before the next word lands
	task sample(input int h);
		if (read_data_oe === 1'b1) begin
			cap_q.push_back(read_data);
			cap_h.push_back(h);
		end
		if (!h[0] && {returned_strobe, returned_strobe_n} !== 2'h2)
			rs_bad++;
	endtask
	// One strobe period: select and address, then two data beats
	task slot(input logic rd, input logic wr, input logic [ADDR_W-1:0] a, input logic [71:0] d,
		input logic [7:0] m, input logic wacc);
		vn = v1;
		pn = p1;
		v1 = v2;
		p1 = p2;
		v2 = 1'b0;
		// A refused start carries no data beats
		if (wacc) begin
			v1 = 1'b1;
			v2 = 1'b1;
			p1 = {m[3:2], d[35:18], m[1:0], d[17:0]};
			p2 = {m[7:6], d[71:54], m[5:4], d[53:36]};
		end
		master_strobe = 1'b0;
		read_port_select_n = !rd;
		write_port_select_n = !wr;
		addr = (rd | wr) ? a : ~addr;
		put_word(vn, pn[19:0]);
		#15 sample(2 * slot_n - 1);
		#5 master_strobe = 1'b1;
		master_strobe_n = 1'b0;
		#20 read_port_select_n = 1'b1;
		write_port_select_n = 1'b1;
		addr = ~addr;
		put_word(vn, pn[39:20]);
		#15 sample(2 * slot_n);
		#5 master_strobe = 1'b0;
		master_strobe_n = 1'b1;
		#20 slot_n++;
	endtask
	// Park both strobes high for the quickest restart
	task stop();
		master_strobe = 1'b1;
		master_strobe_n = 1'b1;
	endtask
endmodule // qrsp_ctrl_model

// ### sim/quad_rate_sram_port_logic_tb_top.sv
// Self-checking bench for the burst SRAM port logic and its register bus.
// Assumes qrsp_ctrl_model drives the link pins; seed fixed for repeat runs.
`timescale 1ns/1ps
module quad_rate_sram_port_logic_tb_top;
	import qrsp_pkg::*;
	localparam int AW = 4; // Small array keeps collisions frequent
	logic clk, reset, ce, pll_bypass, single_mode;
	logic master_strobe, master_strobe_n, output_timing_ref, output_timing_ref_n;
	logic read_port_select_n, write_port_select_n, read_data_oe, returned_strobe, returned_strobe_n;
	logic [LANES-1:0] lane_write_mask_n;
	logic [AW-1:0] addr;
	logic [DATA_W-1:0] write_data, read_data;
	logic [3:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, r;
	int n_fail, total_checks, seed;
	logic [DATA_W-1:0] mem [16][4]; // Expected array contents
	logic [DATA_W-1:0] exp_d[$]; // Expected read words
	int exp_h[$]; // Expected output edge of each
	logic lrd, lwr; // Start taken on previous rise
	logic lrd2; // Read taken two rises back
	logic [DATA_W-1:0] lw; // Last word of the newest read burst
	qrsp_port #(.ADDR_W(AW), .PLL_LOCK_CYCLES(50)) uut (.clk, .reset, .ce, .master_strobe, .master_strobe_n,
		.output_timing_ref, .output_timing_ref_n, .read_port_select_n, .write_port_select_n, .lane_write_mask_n,
		.addr, .write_data, .pll_bypass, .read_data, .read_data_oe, .returned_strobe, .returned_strobe_n,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
	qrsp_ctrl_model #(.ADDR_W(AW)) ctrl (.master_strobe, .master_strobe_n, .output_timing_ref,
		.output_timing_ref_n, .read_port_select_n, .write_port_select_n, .lane_write_mask_n, .addr,
		.write_data, .single_mode, .read_data, .read_data_oe, .returned_strobe, .returned_strobe_n);
	// 100 MHz system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Hang guard, well past the expected run length
	initial begin
		#500000;
		n_fail++;
		finish_test();
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// One register access; waits for waitrequest low, no fixed latency assumed
	task av(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			n_fail++;
			$display("[ERR] %0t bus answer missing", $time);
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// Masked merge: mask bit high keeps the stored lane
	function automatic logic [17:0] merge(logic [17:0] o, logic [17:0] n, logic [1:0] mk);
		return {mk[1] ? o[17:9] : n[17:9], mk[0] ? o[8:0] : n[8:0]};
	endfunction
	// Predict arbitration and contents, then run the period
	task op(input logic rd, input logic wr, input logic [3:0] a, input logic [71:0] d, input logic [7:0] m);
		logic ra, wa;
		ra = rd & !lrd;
		wa = wr & !lwr & !ra;
		// PLL on: last word still stands at the next ref_n sample, pins float only after the next ref rise
		if (pll_bypass && lrd2 && !ra) begin
			exp_d.push_back(lw);
			exp_h.push_back(2 * ctrl.slot_n + 3);
		end
		for (int i = 0; i < 4; i++) begin
			if (ra) begin
				exp_d.push_back(mem[a][i]);
				exp_h.push_back(2 * ctrl.slot_n + (pll_bypass ? 3 : 2) + i);
			end
			if (wa)
				mem[a][i] = merge(mem[a][i], d[18*i +: 18], m[2*i +: 2]);
		end
		if (ra)
			lw = mem[a][3];
		lrd2 = lrd;
		lrd = ra;
		lwr = wa;
		ctrl.slot(rd, wr, a, d, m, wa);
	endtask
	task rop(input logic rd, input logic wr, input logic [3:0] a, input logic full);
		logic [95:0] d;
		logic [31:0] m;
		d = {$random(seed), $random(seed), $random(seed)};
		m = full ? 32'h0 : $random(seed);
		op(rd, wr, a, d[71:0], m[7:0]);
	endtask
	task idle(input int n);
		repeat (n) op(1'b0, 1'b0, 4'h0, 72'h0, 8'hFF);
	endtask
	// Random starts on four addresses: repeats, overlaps, forwarding
	task mix(input int n);
		logic [31:0] x;
		repeat (n) begin
			x = $random(seed);
			rop(x[0], x[1], {2'h0, x[3:2]}, 1'b0);
		end
	endtask
	task fill(input int n);
		for (int a = 0; a < n; a++) begin
			rop(1'b0, 1'b1, 4'(a), 1'b1);
			idle(1);
		end
	endtask
	// Compare every captured read word and its edge, then clear
	task drain(input string name);
		idle(4);
		chk(32'(ctrl.cap_q.size()), 32'(exp_d.size()));
		foreach (exp_d[i]) begin
			if (i < ctrl.cap_q.size()) begin
				chk(32'(ctrl.cap_q[i]), 32'(exp_d[i]));
				chk(32'(ctrl.cap_h[i]), 32'(exp_h[i]));
			end
		end
		chk(32'(read_data_oe), 32'h0);
		ctrl.cap_q.delete();
		ctrl.cap_h.delete();
		exp_d.delete();
		exp_h.delete();
		$display("test %s done", name);
	endtask
	initial begin
		{seed, n_fail, total_checks} = {32'd61, 32'd0, 32'd0};
		{reset, ce, pll_bypass, single_mode, lrd, lwr, lrd2} = 7'h70;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		repeat (12) @(posedge clk);
		chk(32'(read_data_oe), 32'h0);
		chk(32'(avs_waitrequest), 32'h1);
		reset <= 1'b0;
		repeat (6) @(posedge clk);
		fork
			idle(12);
			begin
				repeat (70) @(posedge clk);
				av(1'b0, REG_STATUS, 32'h0, r);
			end
		join
		chk(r, 32'h11);
		av(1'b1, REG_CTRL, 32'h0, r);
		av(1'b0, REG_CTRL, 32'h0, r);
		chk(r, 32'h0);
		av(1'b1, REG_CTRL, 32'h1, r);
		av(1'b0, REG_CTRL, 32'h0, r);
		chk(r, 32'h1);
		av(1'b0, 4'hC, 32'h0, r);
		chk(r, 32'h0);
		av(1'b1, REG_CALCNT, 32'hFFFF, r);
		av(1'b0, REG_CALCNT, 32'h0, r);
		chk(r, 32'h0);
		ctrl.stop();
		repeat (20) @(posedge clk);
		av(1'b0, REG_STATUS, 32'h0, r);
		chk(32'(r[0]), 32'h0);
		$display("test registers done");
		fill(16);
		drain("fill");
		for (int a = 0; a < 16; a++) begin
			rop(1'b1, 1'b0, 4'(a), 1'b0);
			rop(1'b0, 1'b1, 4'(a), 1'b0);
		end
		drain("readback");
		mix(200);
		drain("mixed");
		repeat (8) rop(1'b1, 1'b1, 4'h5, 1'b0);
		drain("both selected");
		@(posedge clk);
		pll_bypass <= 1'b0;
		repeat (4) @(posedge clk);
		mix(60);
		drain("bypass off");
		while (ctrl.slot_n < 1018) idle(1);
		av(1'b0, REG_CALCNT, 32'h0, r);
		chk(r, 32'h0);
		while (ctrl.slot_n < 1032) idle(1);
		av(1'b0, REG_CALCNT, 32'h0, r);
		chk(r, 32'h1);
		ctrl.stop();
		@(posedge clk);
		single_mode <= 1'b1;
		reset <= 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		repeat (6) @(posedge clk);
		{lrd, lwr, lrd2} = 3'h0;
		av(1'b0, REG_STATUS, 32'h0, r);
		chk(32'(r[1]), 32'h1);
		fill(4);
		mix(40);
		drain("single clock");
		chk(32'(ctrl.rs_bad), 32'h0);
		finish_test();
	end
endmodule // quad_rate_sram_port_logic_tb_top
